// ### alu_add_unit.sv
// sized adder with carry in, producing sum and n z v c
`timescale 1ns/1ps
module alu_add_unit
  import alu_pkg::*;
(
  // operands
  input  wire logic [31:0] x,
  input  wire logic [31:0] y,
  input  wire logic        cin,
  input  wire size_type    sz,
  // answer
  output logic      [31:0] sum,
  output flags_type        fl
);

  logic [8:0]  s8;
  logic [16:0] s16;
  logic [32:0] s32;
  logic        sx;
  logic        sy;
  logic        ss;

  // one simultaneous addition per width, carry in included
  assign s8  = {1'b0, x[7:0]} + {1'b0, y[7:0]} + {8'h00, cin};
  assign s16 = {1'b0, x[15:0]} + {1'b0, y[15:0]} + {16'h0000, cin};
  assign s32 = {1'b0, x} + {1'b0, y} + {32'h0000_0000, cin};

  // pick the stored width; bits above it read as zero
  assign sum = (sz == sz_byte) ? {24'h000000, s8[7:0]} :
               (sz == sz_word) ? {16'h0000, s16[15:0]} : s32[31:0];
  assign sx  = (sz == sz_byte) ? x[7] : (sz == sz_word) ? x[15] : x[31];
  assign sy  = (sz == sz_byte) ? y[7] : (sz == sz_word) ? y[15] : y[31];
  assign ss  = (sz == sz_byte) ? s8[7] : (sz == sz_word) ? s16[15] : s32[31];

  // flags from the stored value, carry out of its top bit
  assign fl.n = ss;
  assign fl.z = (sum == 32'h0000_0000);
  assign fl.v = (sx == sy) && (ss != sx);
  assign fl.c = (sz == sz_byte) ? s8[8] :
                (sz == sz_word) ? s16[16] : s32[32];

endmodule

// ### alu_pkg.sv
// shared constants, encodings and carrier types of the integer alu
package alu_pkg;

  // register byte offsets on the apb slave
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_OPCODE  = 8'h04;
  localparam logic [7:0] ADDR_OPA     = 8'h08;
  localparam logic [7:0] ADDR_OPB_LO  = 8'h0c;
  localparam logic [7:0] ADDR_OPB_HI  = 8'h10;
  localparam logic [7:0] ADDR_DADDR   = 8'h14;
  localparam logic [7:0] ADDR_FLAGS   = 8'h18;
  localparam logic [7:0] ADDR_STATUS  = 8'h1c;
  localparam logic [7:0] ADDR_RESULT0 = 8'h20;
  localparam logic [7:0] ADDR_RESULT3 = 8'h2c;

  // field positions
  localparam int CTRL_START_BIT   = 0;
  localparam int STAT_BUSY_BIT    = 0;
  localparam int STAT_OVF_BIT     = 1;
  localparam int STAT_FAULT_BIT   = 2;
  localparam int STAT_BADOP_BIT   = 3;
  localparam int STAT_WROTE_BIT   = 4;

  // reset values
  localparam logic [31:0] RST_WORD  = 32'h0000_0000;
  localparam logic [15:0] RST_OPC   = 16'h0000;

  // opcode families: byte/word/long rows at top bits 4,5,6
  localparam logic [2:0] ROW_BYTE  = 3'h4;
  localparam logic [2:0] ROW_LONG  = 3'h6;
  localparam logic [4:0] FAM_ADD2  = 5'h00;
  localparam logic [4:0] FAM_ADD3  = 5'h01;
  localparam logic [4:0] FAM_SET2  = 5'h08;
  localparam logic [4:0] FAM_SET3  = 5'h09;
  localparam logic [4:0] FAM_CLR2  = 5'h0a;
  localparam logic [4:0] FAM_CLR3  = 5'h0b;
  localparam logic [4:0] FAM_CMP   = 5'h11;
  localparam logic [4:0] FAM_TEST  = 5'h13;
  localparam logic [4:0] FAM_ZERO  = 5'h14;
  localparam logic [4:0] FAM_DEC   = 5'h17;

  // single opcodes outside the row scheme
  localparam logic [7:0]  OPC_ILOCK_ADD  = 8'h58;
  localparam logic [7:0]  OPC_ADD_CARRY  = 8'hd8;
  localparam logic [7:0]  OPC_SHIFT_LONG = 8'h78;
  localparam logic [7:0]  OPC_SHIFT_QUAD = 8'h79;
  localparam logic [7:0]  OPC_ZERO_QUAD  = 8'h7c;
  localparam logic [15:0] OPC_ZERO_OCTA  = 16'h7cfd;
  localparam logic [7:0]  OPC_CVT_BW     = 8'h99;
  localparam logic [7:0]  OPC_CVT_BL     = 8'h98;
  localparam logic [7:0]  OPC_CVT_WB     = 8'h33;
  localparam logic [7:0]  OPC_CVT_WL     = 8'h32;
  localparam logic [7:0]  OPC_CVT_LB     = 8'hf6;
  localparam logic [7:0]  OPC_CVT_LW     = 8'hf7;

  // shift count limits
  localparam logic [7:0] SHL_LONG_MAX = 8'd32;
  localparam logic [7:0] SHL_QUAD_MAX = 8'd64;
  localparam logic [7:0] SHR_LONG_MIN = 8'd31;
  localparam logic [7:0] SHR_QUAD_MIN = 8'd63;

  typedef enum logic [2:0] {
    sz_byte = 3'd0, sz_word = 3'd1, sz_long = 3'd2,
    sz_quad = 3'd3, sz_octa = 3'd4
  } size_type;

  typedef enum logic [3:0] {
    cls_none, cls_add, cls_add_carry, cls_ilock_add, cls_shift,
    cls_mask_clear, cls_mask_set, cls_bit_test, cls_zero_fill,
    cls_compare, cls_convert, cls_decrement
  } op_class_type;

  typedef enum logic [2:0] {
    st_idle   = 3'b000,
    st_latch  = 3'b001,
    st_lock   = 3'b011,
    st_exec   = 3'b010,
    st_unlock = 3'b110
  } state_type;

  typedef struct packed {
    op_class_type cls;
    size_type     src_sz;
    size_type     dst_sz;
    logic         writes;
  } decode_type;

  typedef struct packed {
    logic n;
    logic z;
    logic v;
    logic c;
  } flags_type;

endpackage

// ### integer_alu_with_flags.sv
// integer alu with condition flags behind an apb register slave
`timescale 1ns/1ps
module integer_alu_with_flags
  import alu_pkg::*;
(
  // apb slave
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output logic      [31:0]  prdata,
  output logic              pready,
  output logic              pslverr,
  // multiprocessor interlock
  output logic              lock_req,
  input  wire logic         lock_grant,
  // result to operand write-back
  output logic              dest_write,
  output size_type          dest_size,
  output logic      [127:0] dest_data,
  output flags_type         flags,
  // exception events
  output logic              int_overflow,
  output logic              reserved_fault
);

  state_type    state_reg, state_next;
  logic [15:0]  opcode_reg;
  logic [31:0]  opa_reg;
  logic [63:0]  opb_reg;
  logic [31:0]  daddr_reg;
  logic [15:0]  tmp_reg;
  flags_type    flags_reg;
  logic [127:0] result_reg;
  size_type     dsize_reg;
  logic [4:0]   status_reg;
  logic [31:0]  prdata_reg;
  logic         slverr_reg;
  logic         write_reg;
  logic         ovf_reg;
  logic         fault_reg;

  // apb decode
  logic        wr_en;
  logic        setup;
  logic        hit;
  logic [31:0] rd_mux;
  logic        start;
  logic        busy;
  logic        commit;
  logic        fault_now;
  assign wr_en  = psel && penable && pwrite;
  assign setup  = psel && !penable;
  assign hit    = (paddr[1:0] == 2'b00) && (paddr <= ADDR_RESULT3);
  assign busy   = (state_reg != st_idle);
  assign start  = wr_en && (paddr == ADDR_CTRL) && pwdata[CTRL_START_BIT]
                  && !busy;
  assign commit = (state_reg == st_exec);

  // read mux, sampled in the setup cycle
  assign rd_mux = (paddr == ADDR_OPCODE)  ? {16'h0000, opcode_reg} :
                  (paddr == ADDR_OPA)     ? opa_reg :
                  (paddr == ADDR_OPB_LO)  ? opb_reg[31:0] :
                  (paddr == ADDR_OPB_HI)  ? opb_reg[63:32] :
                  (paddr == ADDR_DADDR)   ? daddr_reg :
                  (paddr == ADDR_FLAGS)   ? {28'h0, flags_reg} :
                  (paddr == ADDR_STATUS)  ? {27'h0, status_reg} :
                  (paddr == ADDR_RESULT0) ? result_reg[31:0] :
                  (paddr == 8'h24)        ? result_reg[63:32] :
                  (paddr == 8'h28)        ? result_reg[95:64] :
                  (paddr == ADDR_RESULT3) ? result_reg[127:96] :
                  RST_WORD;

  // opcode decode into class and operand widths
  function automatic decode_type decode_op(input logic [15:0] opc);
    decode_type d;
    size_type   rsz;
    d   = '{cls: cls_none, src_sz: sz_long, dst_sz: sz_long, writes: 1'b0};
    rsz = size_type'({1'b0, opc[6:5]});
    if (opc == OPC_ZERO_OCTA) begin
      d = '{cls: cls_zero_fill, src_sz: sz_octa, dst_sz: sz_octa,
            writes: 1'b1};
    end else if (opc[15:8] != 8'h00) begin
      d.cls = cls_none;
    end else if (opc[7:5] >= ROW_BYTE && opc[7:5] <= ROW_LONG &&
                 opc[4:1] != 4'hc) begin
      d.src_sz = rsz;
      d.dst_sz = rsz;
      d.writes = 1'b1;
      case (opc[4:0])
        FAM_ADD2, FAM_ADD3: d.cls = cls_add;
        FAM_SET2, FAM_SET3: d.cls = cls_mask_set;
        FAM_CLR2, FAM_CLR3: d.cls = cls_mask_clear;
        FAM_ZERO:           d.cls = cls_zero_fill;
        FAM_DEC:            d.cls = cls_decrement;
        FAM_CMP: begin
          d.cls    = cls_compare;
          d.writes = 1'b0;
        end
        FAM_TEST: begin
          d.cls    = cls_bit_test;
          d.writes = 1'b0;
        end
        default: begin
          d.cls    = cls_none;
          d.writes = 1'b0;
        end
      endcase
    end else begin
      d.writes = 1'b1;
      case (opc[7:0])
        // overlapping operands are not detected; result left as summed
        OPC_ILOCK_ADD: begin
          d = '{cls: cls_ilock_add, src_sz: sz_word, dst_sz: sz_word,
                writes: 1'b1};
        end
        OPC_ADD_CARRY:  d.cls = cls_add_carry;
        OPC_SHIFT_LONG: d.cls = cls_shift;
        OPC_SHIFT_QUAD: begin
          d = '{cls: cls_shift, src_sz: sz_quad, dst_sz: sz_quad,
                writes: 1'b1};
        end
        OPC_ZERO_QUAD: begin
          d = '{cls: cls_zero_fill, src_sz: sz_quad, dst_sz: sz_quad,
                writes: 1'b1};
        end
        OPC_CVT_BW: d = '{cls_convert, sz_byte, sz_word, 1'b1};
        OPC_CVT_BL: d = '{cls_convert, sz_byte, sz_long, 1'b1};
        OPC_CVT_WB: d = '{cls_convert, sz_word, sz_byte, 1'b1};
        OPC_CVT_WL: d = '{cls_convert, sz_word, sz_long, 1'b1};
        OPC_CVT_LB: d = '{cls_convert, sz_long, sz_byte, 1'b1};
        OPC_CVT_LW: d = '{cls_convert, sz_long, sz_word, 1'b1};
        default: begin
          d.cls    = cls_none;
          d.writes = 1'b0;
        end
      endcase
    end
    return d;
  endfunction

  // sign extension of a byte/word/long to 32 bits
  function automatic logic [31:0] sext32(input logic [31:0] v,
                                         input size_type    s);
    if (s == sz_byte) begin
      return {{24{v[7]}}, v[7:0]};
    end else if (s == sz_word) begin
      return {{16{v[15]}}, v[15:0]};
    end
    return v;
  endfunction

  // sign bit of a stored value at its width
  function automatic logic sign_of(input logic [127:0] v,
                                   input size_type     s);
    unique case (s)
      sz_byte: return v[7];
      sz_word: return v[15];
      sz_long: return v[31];
      sz_quad: return v[63];
      default: return v[127];
    endcase
  endfunction

  decode_type dec;
  assign dec = decode_op(opcode_reg);

  // adder operand selection
  logic [31:0] add_x;
  logic [31:0] add_y;
  logic        add_ci;
  size_type    add_sz;
  logic [31:0] add_sum;
  flags_type   add_fl;
  assign add_x  = (dec.cls == cls_compare) ? opa_reg : opb_reg[31:0];
  assign add_y  = (dec.cls == cls_compare)   ? ~opb_reg[31:0] :
                  (dec.cls == cls_decrement) ? 32'hffff_ffff :
                  (dec.cls == cls_ilock_add) ? {16'h0000, tmp_reg} :
                  opa_reg;
  assign add_ci = (dec.cls == cls_compare) ||
                  ((dec.cls == cls_add_carry) && flags_reg.c);
  assign add_sz = dec.dst_sz;

  alu_add_unit u_add (
    .x   (add_x),
    .y   (add_y),
    .cin (add_ci),
    .sz  (add_sz),
    .sum (add_sum),
    .fl  (add_fl)
  );

  // arithmetic shift by signed byte count
  logic        cnt_neg;
  logic [7:0]  amt;
  logic [31:0] shl_l;
  logic [31:0] shr_l;
  logic [63:0] shl_q;
  logic [63:0] shr_q;
  logic [31:0] ash_l;
  logic [63:0] ash_q;
  logic        ash_ovf_l;
  logic        ash_ovf_q;
  assign cnt_neg = opa_reg[7];
  assign amt     = cnt_neg ? (8'h00 - opa_reg[7:0]) : opa_reg[7:0];
  assign shl_l   = opb_reg[31:0] << amt;
  assign shr_l   = $signed(opb_reg[31:0]) >>> amt;
  assign shl_q   = opb_reg << amt;
  assign shr_q   = $signed(opb_reg) >>> amt;
  assign ash_l   = cnt_neg ? ((amt >= SHR_LONG_MIN) ?
                              {32{opb_reg[31]}} : shr_l) :
                   ((amt > SHL_LONG_MAX) ? 32'h0000_0000 : shl_l);
  assign ash_q   = cnt_neg ? ((amt >= SHR_QUAD_MIN) ?
                              {64{opb_reg[63]}} : shr_q) :
                   ((amt > SHL_QUAD_MAX) ? 64'h0 : shl_q);
  // bits that pass the sign position must all equal the old sign
  assign ash_ovf_l = !cnt_neg && ((amt >= SHL_LONG_MAX) ?
                     (opb_reg[31:0] != 32'h0) :
                     (($signed(shl_l) >>> amt) != $signed(opb_reg[31:0])));
  assign ash_ovf_q = !cnt_neg && ((amt >= SHL_QUAD_MAX) ?
                     (opb_reg != 64'h0) :
                     (($signed(shl_q) >>> amt) != $signed(opb_reg)));

  // width convert
  logic [31:0] cvt_src;
  logic [31:0] cvt_res;
  assign cvt_src = sext32(opa_reg, dec.src_sz);
  assign cvt_res = sext32(cvt_src, dec.dst_sz);

  // result and flag computation for the decoded operation
  logic [127:0] res_c;
  flags_type    fl_c;
  always_comb begin
    res_c = 128'h0;
    fl_c  = flags_reg;
    unique case (dec.cls)
      cls_add, cls_add_carry, cls_ilock_add, cls_decrement: begin
        res_c = {96'h0, add_sum};
        fl_c  = add_fl;
        if (dec.cls == cls_decrement) begin
          fl_c.c = !add_fl.c;
        end
      end
      cls_compare: begin
        fl_c.n = add_fl.n ^ add_fl.v;
        fl_c.z = add_fl.z;
        fl_c.v = 1'b0;
        fl_c.c = !add_fl.c;
      end
      cls_shift: begin
        res_c  = (dec.dst_sz == sz_quad) ? {64'h0, ash_q} : {96'h0, ash_l};
        fl_c.v = (dec.dst_sz == sz_quad) ? ash_ovf_q : ash_ovf_l;
        fl_c.c = 1'b0;
      end
      cls_mask_clear, cls_mask_set, cls_bit_test: begin
        res_c  = (dec.cls == cls_mask_set) ? {96'h0, opb_reg[31:0] | opa_reg}
               : (dec.cls == cls_mask_clear)
               ? {96'h0, opb_reg[31:0] & ~opa_reg}
               : {96'h0, opb_reg[31:0] & opa_reg};
        res_c  = (dec.dst_sz == sz_byte) ? (res_c & 128'hff) :
                 (dec.dst_sz == sz_word) ? (res_c & 128'hffff) : res_c;
        fl_c.v = 1'b0;
      end
      cls_zero_fill: begin
        fl_c.v = 1'b0;
      end
      cls_convert: begin
        res_c  = (dec.dst_sz == sz_byte) ? {120'h0, cvt_res[7:0]} :
                 (dec.dst_sz == sz_word) ? {112'h0, cvt_res[15:0]} :
                 {96'h0, cvt_res};
        fl_c.v = (cvt_res != cvt_src);
        fl_c.c = 1'b0;
      end
      cls_none: begin
        fl_c = flags_reg;
      end
    endcase
    if (dec.cls != cls_none && dec.cls != cls_compare) begin
      fl_c.n = sign_of(res_c, dec.dst_sz);
      fl_c.z = (res_c == 128'h0);
    end
  end

  // sequencing: plain ops execute at once, the interlocked add locks
  assign fault_now = start && (dec.cls == cls_ilock_add) && daddr_reg[0];
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      st_idle: begin
        if (start && !fault_now) begin
          state_next = (dec.cls == cls_ilock_add) ? st_latch : st_exec;
        end
      end
      st_latch:  state_next = st_lock;
      st_lock:   state_next = lock_grant ? st_exec : st_lock;
      st_exec:   state_next = (dec.cls == cls_ilock_add) ? st_unlock : st_idle;
      st_unlock: state_next = st_idle;
      default:   state_next = st_idle;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= st_idle;
      tmp_reg   <= 16'h0000;
    end else begin
      state_reg <= state_next;
      if (state_reg == st_latch) begin
        tmp_reg <= opa_reg[15:0];
      end
    end
  end

  // software registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opcode_reg <= RST_OPC;
      opa_reg    <= RST_WORD;
      opb_reg    <= {RST_WORD, RST_WORD};
      daddr_reg  <= RST_WORD;
    end else if (wr_en) begin
      if (paddr == ADDR_OPCODE) opcode_reg <= pwdata[15:0];
      if (paddr == ADDR_OPA) opa_reg <= pwdata;
      if (paddr == ADDR_OPB_LO) opb_reg[31:0] <= pwdata;
      if (paddr == ADDR_OPB_HI) opb_reg[63:32] <= pwdata;
      if (paddr == ADDR_DADDR) daddr_reg <= pwdata;
    end
  end

  // results, flags and events; a commit wins over a flags write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_reg  <= '0;
      result_reg <= 128'h0;
      dsize_reg  <= sz_long;
      status_reg <= 5'h00;
      write_reg  <= 1'b0;
      ovf_reg    <= 1'b0;
      fault_reg  <= 1'b0;
    end else begin
      write_reg <= commit && dec.writes;
      ovf_reg   <= commit && fl_c.v;
      fault_reg <= fault_now;
      status_reg[STAT_BUSY_BIT] <= (state_next != st_idle);
      if (commit) begin
        flags_reg  <= fl_c;
        result_reg <= dec.writes ? res_c : result_reg;
        dsize_reg  <= dec.dst_sz;
        status_reg[STAT_OVF_BIT]   <= fl_c.v;
        status_reg[STAT_BADOP_BIT] <= (dec.cls == cls_none);
        status_reg[STAT_WROTE_BIT] <= dec.writes;
      end else if (wr_en && paddr == ADDR_FLAGS) begin
        flags_reg <= pwdata[3:0];
      end
      if (start) begin
        status_reg[STAT_FAULT_BIT] <= fault_now;
      end
    end
  end

  // apb read data and error captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= RST_WORD;
      slverr_reg <= 1'b0;
    end else if (setup) begin
      prdata_reg <= rd_mux;
      slverr_reg <= !hit;
    end
  end

  assign pready         = psel && penable;
  assign pslverr        = psel && penable && slverr_reg;
  assign prdata         = prdata_reg;
  assign lock_req       = (state_reg == st_lock) || (state_reg == st_exec &&
                          dec.cls == cls_ilock_add);
  assign dest_write     = write_reg;
  assign dest_size      = dsize_reg;
  assign dest_data      = result_reg;
  assign flags          = flags_reg;
  assign int_overflow   = ovf_reg;
  assign reserved_fault = fault_reg;

  // checks
  chk_zero_flag_match: assert property (@(posedge pclk) disable iff (!presetn)
    commit && dec.writes |=> flags_reg.z == (result_reg == 128'h0))
    else $error("zero flag does not match stored result");
  chk_clear_result: assert property (@(posedge pclk) disable iff (!presetn)
    commit && dec.cls == cls_zero_fill |=> result_reg == 128'h0 &&
    flags_reg.z && !flags_reg.n && !flags_reg.v)
    else $error("clear did not give zero with n0 z1 v0");
  chk_ovf_event: assert property (@(posedge pclk) disable iff (!presetn)
    int_overflow |-> flags_reg.v && status_reg[STAT_OVF_BIT])
    else $error("overflow event without overflow flag");
  chk_odd_fault: assert property (@(posedge pclk) disable iff (!presetn)
    fault_now |=> reserved_fault && state_reg == st_idle ##1 !dest_write)
    else $error("odd destination did not fault");
  chk_lock_held: assert property (@(posedge pclk) disable iff (!presetn)
    commit && dec.cls == cls_ilock_add |-> lock_req ##1 !lock_req)
    else $error("interlock not held across the add");
  chk_shift_carry: assert property (@(posedge pclk) disable iff (!presetn)
    commit && dec.cls == cls_shift |=> !flags_reg.c)
    else $error("shift left carry set");
  chk_test_nowrite: assert property (@(posedge pclk) disable iff (!presetn)
    commit && !dec.writes |=> !dest_write)
    else $error("compare or test wrote a destination");
  chk_mask_carry: assert property (@(posedge pclk) disable iff (!presetn)
    commit && (dec.cls == cls_mask_set || dec.cls == cls_mask_clear)
    |=> flags_reg.c == $past(flags_reg.c) && !flags_reg.v)
    else $error("mask op changed carry or set overflow");
  chk_carry_add: assert property (@(posedge pclk) disable iff (!presetn)
    commit && dec.cls == cls_add_carry |=> {flags_reg.c, result_reg[31:0]}
    == {1'b0, $past(opb_reg[31:0])} + {1'b0, $past(opa_reg)}
       + {32'h0, $past(flags_reg.c)})
    else $error("add with carry sum wrong");
  chk_dec_wrap: assert property (@(posedge pclk) disable iff (!presetn)
    commit && dec.cls == cls_decrement && dec.dst_sz == sz_long &&
    opb_reg[31:0] == 32'h8000_0000 |=> result_reg[31:0] == 32'h7fff_ffff
    && flags_reg.v && int_overflow)
    else $error("decrement of most negative did not wrap");

endmodule

// ### integer_alu_with_flags_tb.sv
// self-checking bench of the integer alu over apb
`timescale 1ns/1ps
module integer_alu_with_flags_tb;
  import alu_pkg::*;
  logic         pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic         pwrite = 1'b0, pready, pslverr, err, lock_req, lock_grant;
  logic         dest_write, int_overflow, reserved_fault;
  logic [7:0]   paddr = 8'h00;
  logic [31:0]  pwdata = 32'h0, prdata, q, st;
  logic [127:0] dest_data;
  size_type     dest_size;
  flags_type    flags;
  int           miscompares = 0, total_checks = 0;
  int           n_wr = 0, n_ovf = 0, n_flt = 0, n_lock = 0;
  logic         lock_q = 1'b0;
  // count result pulses and interlock requests seen at the pins
  always @(posedge pclk) begin
    n_wr += (dest_write === 1'b1);
    n_ovf += (int_overflow === 1'b1);
    n_flt += (reserved_fault === 1'b1);
    n_lock += (lock_req === 1'b1 && !lock_q);
    lock_q = (lock_req === 1'b1);
  end
  integer_alu_with_flags u_integer_alu_with_flags (.*);
  lock_model u_lock_model (.*);
  initial forever #2.5 pclk = ~pclk;
  // verdict and end of run
  task automatic finish_test;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic compare(input string nm, input logic [127:0] e, g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      miscompares++;
      finish_test();
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // start an operation, poll busy, judge result and flags
  task automatic run(input logic [15:0] op, input logic [31:0] a, b, r,
                     input logic [3:0] f);
    int n = 0;
    apb(1'b1, ADDR_OPCODE, {16'h0, op});
    apb(1'b1, ADDR_OPA, a);
    apb(1'b1, ADDR_OPB_LO, b);
    apb(1'b1, ADDR_CTRL, 32'h1);
    do begin
      apb(1'b0, ADDR_STATUS, 32'h0);
      n++;
    end while (q[STAT_BUSY_BIT] !== 1'b0 && n < 20);
    if (n >= 20) begin
      miscompares++;
      finish_test();
    end
    st = q;
    compare("result", {96'h0, r}, dest_data);
    compare("flags", {124'h0, f}, flags);
  endtask
  task automatic t_arith;
    run(16'hc0, 32'h7fffffff, 32'h1, 32'h80000000, 4'ha);
    run(16'h80, 32'hff, 32'h1, 32'h0, 4'h5);
    run(16'ha1, 32'h8000, 32'h8000, 32'h0, 4'h7);
    apb(1'b1, ADDR_FLAGS, 32'h1);
    run(16'hd8, 32'hffffffff, 32'h0, 32'h0, 4'h5);
    $display("test arith done");
  endtask
  task automatic t_shift;
    run(16'h78, 32'h1, 32'h40000000, 32'h80000000, 4'ha);
    run(16'h78, 32'he0, 32'h80000000, 32'hffffffff, 4'h8);
    run(16'h78, 32'h21, 32'h1, 32'h0, 4'h6);
    $display("test shift done");
  endtask
  task automatic t_logic;
    apb(1'b1, ADDR_FLAGS, 32'h1);
    run(16'hca, 32'hffff, 32'hffffffff, 32'hffff0000, 4'h9);
    run(16'hc8, 32'h1, 32'h0, 32'h1, 4'h1);
    run(16'hd3, 32'h80000000, 32'h80000000, 32'h1, 4'h9);
    run(16'hd4, 32'h0, 32'h0, 32'h0, 4'h5);
    run(16'hd1, 32'h1, 32'h2, 32'h0, 4'h9);
    run(16'hf6, 32'h180, 32'h0, 32'h80, 4'ha);
    run(16'h99, 32'h80, 32'h0, 32'hff80, 4'h8);
    run(16'hd7, 32'h0, 32'h80000000, 32'h7fffffff, 4'h2);
    $display("test logic done");
  endtask
  task automatic t_ilock;
    apb(1'b1, ADDR_DADDR, 32'h1);
    run(16'h58, 32'h1, 32'h0, 32'h7fffffff, 4'h2);
    compare("fault", 128'h1, {127'h0, st[STAT_FAULT_BIT]});
    apb(1'b1, ADDR_DADDR, 32'h2);
    run(16'h58, 32'h1, 32'h7fff, 32'h8000, 4'ha);
    apb(1'b0, 8'h30, 32'h0);
    compare("pslverr", 128'h1, {127'h0, err});
    compare("writes", 128'he, n_wr);
    compare("ovf events", 128'h7, n_ovf);
    compare("faults", 128'h1, n_flt);
    compare("lock grabs", 128'h1, n_lock);
    compare("size", {125'h0, sz_word}, {125'h0, dest_size});
    $display("test interlock done");
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_arith();
    t_shift();
    t_logic();
    t_ilock();
    finish_test();
  end
endmodule

// ### lock_model.sv
// interlock arbiter model granting after a short wait
`timescale 1ns/1ps
module lock_model (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // interlock handshake
  input  wire logic lock_req,
  output logic      lock_grant
);
  logic [1:0] wait_reg;
  // grant two cycles after a request, hold until it drops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_reg   <= 2'h0;
      lock_grant <= 1'b0;
    end else begin
      wait_reg   <= lock_req ? 2'h1 : 2'h0;
      lock_grant <= lock_req && (lock_grant || wait_reg == 2'h1);
    end
  end
endmodule
